// ---- bench/data_eeprom_write_control_test.sv ----
// Self-checking bench for the data EEPROM write control block.
// Assumes dewc_ctrl with a short write time and the core model beside it.
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin mismatches++; \
    $display("ERROR %0t: got %h expected %h", $time, (got), (exp)); end end
module data_eeprom_write_control_test
    import dewc_pkg::*;
;
    localparam int unsigned WC = 20;
    logic          mclk = 1'b0;
    logic          rst_n, master_clear_reset_wdt_rst, pwrt_active, avs_read, avs_write;
    logic          avs_waitrequest, psv_suspend, ee_busy, irq, ok, busy_q;
    logic [4:0]    avs_address;
    logic [31:0]   avs_writedata, avs_readdata, rq;
    logic [15:0]   q16;
    dewc_tbl_req_s tbl_req;
    dewc_tbl_rsp_s tbl_rsp;
    int            mismatches, n_compared, cyc, busy_len;

    always #2.5 mclk = ~mclk;

    // Length of the latest busy stretch, start edge to final commit edge
    always @(posedge mclk) begin
        busy_q   <= ee_busy;
        busy_len <= !ee_busy ? busy_len : busy_q ? busy_len + 1 : 1;
    end

    dewc_ctrl #(.WRITE_CYCLES(WC)) DUT (.mclk(mclk), .rst_n(rst_n), .master_clear_reset_wdt_rst(master_clear_reset_wdt_rst),
        .pwrt_active(pwrt_active), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .tbl_req(tbl_req), .tbl_rsp(tbl_rsp), .psv_suspend(psv_suspend), .ee_busy(ee_busy), .irq(irq));
    dewc_core_model core (.mclk(mclk), .rst_n(rst_n), .tbl_req(tbl_req), .tbl_rsp(tbl_rsp),
        .psv_suspend(psv_suspend));

    // Avalon transfer held until waitrequest is sampled low
    task automatic xfer(input logic wr, input logic [4:0] a, input logic [31:0] d);
        int n;
        n = 0;
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= wr;
        avs_read      <= ~wr;
        do begin
            @(posedge mclk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 100);
        rq = avs_readdata;
        if (n >= 100) begin
            mismatches++;
            $display("ERROR %0t: bus timeout", $time);
        end
        avs_write     <= 1'b0;
        avs_read      <= 1'b0;
        avs_address   <= ~a;
        avs_writedata <= ~d;
        @(posedge mclk);
    endtask : xfer

    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask : wr

    task automatic rd(input logic [4:0] a);
        xfer(1'b0, a, 32'h0);
    endtask : rd

    task automatic launch(input logic [15:0] ctl);
        wr(OFS_UNLOCK, 32'h55);
        wr(OFS_UNLOCK, 32'haa);
        wr(OFS_CONTROL, {16'h0, ctl});
    endtask : launch

    // Waits for the array to go idle, counting busy cycles
    task automatic wait_idle();
        cyc = 0;
        while (ee_busy !== 1'b0 && cyc < 5000) begin
            @(posedge mclk);
            cyc++;
        end
    endtask : wait_idle

    task automatic t_reset();
        rd(OFS_CONTROL);
        `CHK(rq, 32'h0)
        rd(OFS_IRQ_FLAGS);
        `CHK(rq, 32'h0)
        rd(5'h18);
        `CHK(rq, 32'h0)
        rd(OFS_UNLOCK);
        `CHK(rq, 32'h0)
        `CHK(irq, 1'b0)
        $display("reset test done");
    endtask : t_reset

    task automatic t_word();
        wr(OFS_ADDR_UP, 32'h7f);
        wr(OFS_ADDR_LOW, 32'hf010);
        launch(16'hc005);
        `CHK(ee_busy, 1'b1)
        wr(OFS_CONTROL, 32'h4005);
        rd(OFS_CONTROL);
        `CHK(rq[15], 1'b1)
        core.access(1'b0, 24'h7ff010, 16'h0, q16, ok);
        `CHK(ok, 1'b1)
        wait_idle();
        `CHK(busy_len, WC + 2)
        rd(OFS_CONTROL);
        `CHK(rq[15], 1'b0)
        rd(OFS_IRQ_FLAGS);
        `CHK(rq[1:0], 2'h1)
        `CHK(irq, 1'b0)
        core.access(1'b1, 24'h7ff010, 16'h3c5a, q16, ok);
        `CHK(ok, 1'b1)
        rd(OFS_ADDR_LOW);
        `CHK(rq[15:0], 16'hf010)
        rd(OFS_ADDR_UP);
        `CHK(rq[7:0], 8'h7f)
        launch(16'hc004);
        wait_idle();
        core.access(1'b0, 24'h7ff010, 16'h0, q16, ok);
        `CHK(q16, 16'h3c5a)
        wr(OFS_IRQ_MASK, 32'h1);
        @(posedge mclk);
        `CHK(irq, 1'b1)
        wr(OFS_IRQ_FLAGS, 32'h1);
        @(posedge mclk);
        `CHK(irq, 1'b0)
        $display("word test done");
    endtask : t_word

    task automatic t_block();
        wr(OFS_ADDR_LOW, 32'hf020);
        launch(16'hc006);
        wait_idle();
        for (int i = 0; i < 16; i++) begin
            core.access(1'b1, 24'h7ff020 + 24'(2 * i), 16'ha000 + 16'(i), q16, ok);
        end
        rd(OFS_ADDR_LOW);
        `CHK(rq[15:0], 16'hf03e)
        core.access(1'b0, 24'h7ff020, 16'h0, q16, ok);
        `CHK(q16, ERASED_WORD)
        wr(OFS_CONTROL, 32'h400a);
        launch(16'hc00a);
        rd(OFS_CONTROL);
        `CHK(rq[15:0], 16'hc00a)
        wait_idle();
        `CHK(busy_len, WC + 17)
        for (int i = 0; i < 16; i++) begin
            core.access(1'b0, 24'h7ff020 + 24'(2 * i), 16'h0, q16, ok);
            `CHK(q16, 16'ha000 + 16'(i))
        end
        wr(OFS_IRQ_FLAGS, 32'h3);
        $display("block test done");
    endtask : t_block

    task automatic t_refuse();
        wr(OFS_CONTROL, 32'hc004);
        `CHK(ee_busy, 1'b0)
        launch(16'h8004);
        `CHK(ee_busy, 1'b0)
        pwrt_active <= 1'b1;
        launch(16'hc004);
        `CHK(ee_busy, 1'b0)
        pwrt_active <= 1'b0;
        core.access(1'b0, 24'h7feffe, 16'h0, q16, ok);
        `CHK(q16, 16'h0)
        core.access(1'b1, 24'h001000, 16'h1234, q16, ok);
        rd(OFS_ADDR_LOW);
        `CHK(rq[15:0], 16'hf03e)
        $display("refusal test done");
    endtask : t_refuse

    task automatic t_abort();
        wr(OFS_IRQ_MASK, 32'h3);
        launch(16'hc004);
        repeat (3) @(posedge mclk);
        master_clear_reset_wdt_rst <= 1'b1;
        @(posedge mclk);
        master_clear_reset_wdt_rst <= 1'b0;
        @(posedge mclk);
        `CHK(ee_busy, 1'b0)
        `CHK(irq, 1'b1)
        rd(OFS_CONTROL);
        `CHK(rq[15:13], 3'b001)
        rd(OFS_IRQ_FLAGS);
        `CHK(rq[1:0], 2'h2)
        rd(OFS_ADDR_LOW);
        `CHK(rq[15:0], 16'hf03e)
        $display("abort test done");
    endtask : t_abort

    task automatic tally_and_finish();
        $display("compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : tally_and_finish

    initial begin
        #200000;
        mismatches++;
        $display("ERROR %0t: watchdog expired", $time);
        tally_and_finish();
    end

    initial begin
        mismatches    = 0;
        n_compared    = 0;
        rst_n         = 1'b0;
        master_clear_reset_wdt_rst  = 1'b0;
        pwrt_active   = 1'b0;
        avs_address   = 5'h0;
        avs_read      = 1'b0;
        avs_write     = 1'b0;
        avs_writedata = 32'h0;
        repeat (12) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        t_reset();
        t_word();
        t_block();
        t_refuse();
        t_abort();
        tally_and_finish();
    end
endmodule : data_eeprom_write_control_test
`default_nettype wire

// ---- bench/dewc_core_model.sv ----
// Processor core model issuing table reads and writes to the EEPROM block.
// Assumes callers enter its task just after a rising edge of mclk.
`timescale 1ns/1ps
`default_nettype none
module dewc_core_model
    import dewc_pkg::*;
(
    // Clock and reset
    input  wire logic          mclk,
    input  wire logic          rst_n,
    // Table port
    output var dewc_tbl_req_s  tbl_req,
    input  wire dewc_tbl_rsp_s tbl_rsp,
    input  wire logic          psv_suspend
);
    initial tbl_req = '0;

    // One-cycle request, answer sampled at the following edge
    task automatic access(input logic wr, input logic [23:0] a, input logic [15:0] d,
                          output logic [15:0] q, output logic ok);
        tbl_req <= '{valid: 1'b1, write: wr, addr: a, wdata: d};
        @(posedge mclk);
        tbl_req <= '{valid: 1'b0, write: ~wr, addr: ~a, wdata: ~d};
        @(posedge mclk);
        q  = tbl_rsp.rdata;
        ok = (tbl_rsp.valid === 1'b1) && (psv_suspend === 1'b1);
    endtask : access
endmodule : dewc_core_model
`default_nettype wire

// ---- verilog/dewc_ctrl.sv ----
// Data EEPROM write control: register file, unlock, block latch, array and write timing.
// Assumes a core that raises one-cycle table requests and an Avalon-MM master for the registers.
`timescale 1ns/1ps
`default_nettype none
module dewc_ctrl
    import dewc_pkg::*;
#(
    parameter int unsigned WRITE_CYCLES = WRITE_CYCLES_DEF
) (
    // Clock and power-up reset
    input  wire logic          mclk,
    input  wire logic          rst_n,
    // Master clear or watchdog reset event, power-up timer
    input  wire logic          master_clear_reset_wdt_rst,
    input  wire logic          pwrt_active,
    // Avalon-MM register slave
    input  wire logic [4:0]    avs_address,
    input  wire logic          avs_read,
    input  wire logic          avs_write,
    input  wire logic [31:0]   avs_writedata,
    output logic [31:0]        avs_readdata,
    output logic               avs_waitrequest,
    // Core table access
    input  wire dewc_tbl_req_s tbl_req,
    output dewc_tbl_rsp_s      tbl_rsp,
    // Status
    output logic               psv_suspend,
    output logic               ee_busy,
    output logic               irq
);
    dewc_state_s st_ff;
    dewc_state_s nxt_st;

    logic [15:0]         ee_mem [EE_WORDS];
    logic [15:0]         blk_latch [BLK_WORDS];
    logic [15:0]         rd_ff;
    logic                mem_we;
    logic [EE_IDX_W-1:0] mem_waddr;
    logic [15:0]         mem_wdata;
    logic                lat_we;
    logic [BLK_W-1:0]    lat_widx;
    logic [15:0]         lat_wdata;
    logic                tmr_start;
    logic                tmr_abort;
    logic                tmr_running;
    logic                tmr_expired;
    logic                bus_wr;
    logic                armed;
    logic                tbl_in_ee;
    logic                tgt_in_ee;
    logic                op_block;
    logic                op_erase;
    logic [23:0]         tgt_addr;
    logic [EE_IDX_W-1:0] tgt_idx;
    logic [EE_IDX_W-1:0] tbl_idx;
    logic [PROG_CNT_W-1:0] prog_cnt;

    // Address decode of the EEPROM window
    assign tbl_in_ee = (tbl_req.addr >= EE_BASE) && (tbl_req.addr <= EE_LAST);            // [R1]
    assign tgt_addr  = {st_ff.addr_up, st_ff.addr_low};                                    // [R3]
    assign tgt_in_ee = (tgt_addr >= EE_BASE) && (tgt_addr <= EE_LAST);
    assign tgt_idx   = st_ff.addr_low[EE_IDX_W:1];
    assign tbl_idx   = tbl_req.addr[EE_IDX_W:1];
    assign op_block  = (st_ff.op == OP_BLOCK_WRITE) || (st_ff.op == OP_BLOCK_ERASE);      // [R2] [R13]
    assign op_erase  = (st_ff.op == OP_WORD_ERASE) || (st_ff.op == OP_BLOCK_ERASE);
    assign bus_wr    = avs_write && !st_ff.wait_req;
    assign armed     = (st_ff.key == KEY_ARMED);

    always_comb begin
        nxt_st    = st_ff;
        mem_we    = 1'b0;
        mem_waddr = '0;
        mem_wdata = '0;
        lat_we    = 1'b0;
        lat_widx  = '0;
        lat_wdata = '0;
        tmr_start = 1'b0;
        tmr_abort = 1'b0;

        // Bus handshake: wait one cycle, then answer
        if (avs_read || avs_write) begin
            if (st_ff.wait_req) begin
                nxt_st.wait_req = 1'b0;
                unique case (avs_address)
                    OFS_CONTROL:   nxt_st.rdata = {16'h0000, st_ff.go, st_ff.permit, st_ff.fault,
                                                   9'h000, st_ff.op};
                    OFS_ADDR_LOW:  nxt_st.rdata = {16'h0000, st_ff.addr_low};
                    OFS_ADDR_UP:   nxt_st.rdata = {24'h000000, st_ff.addr_up};
                    OFS_IRQ_FLAGS: nxt_st.rdata = {30'h00000000, st_ff.flags};
                    OFS_IRQ_MASK:  nxt_st.rdata = {30'h00000000, st_ff.mask};
                    default:       nxt_st.rdata = 32'h0000_0000;
                endcase
            end else begin
                nxt_st.wait_req = 1'b1;
            end
        end

        // Register writes
        if (bus_wr) begin
            unique case (avs_address)
                OFS_CONTROL: begin
                    nxt_st.key    = KEY_NONE;
                    nxt_st.permit = avs_writedata[CTL_PERMIT_BIT];
                    nxt_st.fault  = avs_writedata[CTL_FAULT_BIT];
                    if (st_ff.fsm == S_IDLE) begin
                        nxt_st.op = avs_writedata[CTL_OP_LSB +: CTL_OP_W];
                    end
                    // Zero in the go bit is ignored
                    if (avs_writedata[CTL_GO_BIT] && armed && nxt_st.permit && !pwrt_active &&
                        tgt_in_ee && (st_ff.fsm == S_IDLE)) begin                    // [R8] [R9] [R12] [R15]
                        nxt_st.go   = 1'b1;
                        nxt_st.fsm  = S_PROGRAM;
                        nxt_st.cidx = '0;
                        tmr_start   = 1'b1;
                    end
                end
                OFS_ADDR_LOW: nxt_st.addr_low = avs_writedata[15:0];
                OFS_ADDR_UP:  nxt_st.addr_up  = avs_writedata[7:0];
                OFS_UNLOCK: begin
                    if (avs_writedata[7:0] == KEY_FIRST) begin
                        nxt_st.key = KEY_HALF;
                    end else if ((avs_writedata[7:0] == KEY_SECOND) && (st_ff.key == KEY_HALF)) begin
                        nxt_st.key = KEY_ARMED;                                              // [R12]
                    end else begin
                        nxt_st.key = KEY_NONE;
                    end
                end
                OFS_IRQ_FLAGS: nxt_st.flags = st_ff.flags & ~avs_writedata[IRQ_W-1:0];
                OFS_IRQ_MASK:  nxt_st.mask  = avs_writedata[IRQ_W-1:0];
                default: begin
                end
            endcase
        end

        // Table accesses are answered at once, busy or not
        nxt_st.rvalid   = tbl_req.valid;                                                     // [R5] [R17]
        nxt_st.psv_hold = tbl_req.valid;                                                     // [R18]
        if (tbl_req.valid && tbl_req.write && tbl_in_ee) begin
            lat_we          = 1'b1;                                                          // [R19]
            lat_widx        = tbl_req.addr[BLK_W:1];
            lat_wdata       = tbl_req.wdata;
            nxt_st.addr_low = tbl_req.addr[15:0];                                            // [R14]
            nxt_st.addr_up  = tbl_req.addr[23:16];
        end

        // Program and commit sequencing
        unique case (st_ff.fsm)
            S_IDLE: begin
            end
            S_PROGRAM: begin
                if (tmr_expired) begin
                    nxt_st.fsm = S_COMMIT;                                                   // [R4]
                end
            end
            S_COMMIT: begin
                mem_we = 1'b1;                                                               // [R19]
                if (op_block) begin
                    mem_waddr = {tgt_idx[EE_IDX_W-1:BLK_W], st_ff.cidx};                     // [R2]
                    mem_wdata = op_erase ? ERASED_WORD : blk_latch[st_ff.cidx];
                end else begin
                    mem_waddr = tgt_idx;
                    mem_wdata = op_erase ? ERASED_WORD : blk_latch[tgt_idx[BLK_W-1:0]];
                end
                if (!op_block || (st_ff.cidx == 4'hf)) begin
                    nxt_st.fsm                = S_IDLE;
                    nxt_st.go                 = 1'b0;                                        // [R8]
                    nxt_st.flags[IRQ_DONE_BIT] = 1'b1;                                       // [R11]
                end else begin
                    nxt_st.cidx = st_ff.cidx + 4'h1;
                end
            end
        endcase

        // Master clear or watchdog reset: abort and flag, address kept
        if (master_clear_reset_wdt_rst) begin
            if (st_ff.fsm != S_IDLE) begin
                nxt_st.fault                = 1'b1;                                          // [R10]
                nxt_st.flags[IRQ_FAULT_BIT] = 1'b1;
            end
            tmr_abort     = 1'b1;
            mem_we        = 1'b0;
            nxt_st.fsm    = S_IDLE;
            nxt_st.go     = 1'b0;
            nxt_st.permit = 1'b0;
            nxt_st.key    = KEY_NONE;
            nxt_st.op     = 4'h0;
            nxt_st.cidx   = '0;
        end

        nxt_st.busy = (nxt_st.fsm != S_IDLE);
        nxt_st.irq  = |(nxt_st.flags & nxt_st.mask);
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= ST_RST;                                                                 // [R9]
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Array and block latch
    always_ff @(posedge mclk) begin
        if (mem_we) begin
            ee_mem[mem_waddr] <= mem_wdata;
        end
        if (lat_we) begin
            blk_latch[lat_widx] <= lat_wdata;
        end
    end

    // Read port; data during programming is not guaranteed
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rd_ff <= 16'h0000;
        end else if (tbl_req.valid && !tbl_req.write) begin
            rd_ff <= tbl_in_ee ? ee_mem[tbl_idx] : 16'h0000;                                // [R7] [R17]
        end
    end

    dewc_timer #(
        .W (CNT_W)
    ) u_timer (
        .mclk    (mclk),
        .rst_n   (rst_n),
        .load    (CNT_W'(WRITE_CYCLES)),                                                     // [R4]
        .start   (tmr_start),
        .abort   (tmr_abort),
        .running (tmr_running),
        .expired (tmr_expired)
    );

    assign avs_readdata    = st_ff.rdata;
    assign avs_waitrequest = st_ff.wait_req;
    assign tbl_rsp         = '{valid: st_ff.rvalid, rdata: rd_ff};
    assign psv_suspend     = st_ff.psv_hold;
    assign ee_busy         = st_ff.busy;
    assign irq             = st_ff.irq;

    // Cycles spent in the program phase
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            prog_cnt <= '0;
        end else if (st_ff.fsm == S_PROGRAM) begin
            prog_cnt <= prog_cnt + PROG_CNT_W'(1);
        end else begin
            prog_cnt <= '0;
        end
    end

    default clocking dewc_cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    key_gate_a: assert property ($rose(st_ff.go) |-> $past(st_ff.key) == KEY_ARMED) // [R12]
        else $error("go set without unlock sequence");

    pwrt_gate_a: assert property ($rose(st_ff.go) |-> !$past(pwrt_active)) // [R15]
        else $error("write started while power-up timer ran");

    permit_gate_a: assert property ($rose(st_ff.go) |-> st_ff.permit && st_ff.fsm == S_PROGRAM) // [R9]
        else $error("write started without permit");

    write_time_a: assert property ($rose(st_ff.fsm == S_COMMIT) |-> prog_cnt == PROG_CNT_W'(WRITE_CYCLES + 1)) // [R4]
        else $error("program phase length wrong");

    timer_idle_a: assert property (st_ff.fsm != S_PROGRAM |-> !tmr_running) // [R4]
        else $error("timer running outside program phase");

    go_held_a: assert property (st_ff.go && st_ff.fsm == S_PROGRAM && !master_clear_reset_wdt_rst |=> st_ff.go) // [R8]
        else $error("go cleared before completion");

    done_flag_a: assert property ($fell(st_ff.go) && !$past(master_clear_reset_wdt_rst) |-> st_ff.flags[IRQ_DONE_BIT]) // [R11]
        else $error("done flag not set at completion");

    done_sticky_a: assert property (st_ff.flags[IRQ_DONE_BIT] && !(bus_wr && avs_address == OFS_IRQ_FLAGS &&
                                    avs_writedata[IRQ_DONE_BIT]) |=> st_ff.flags[IRQ_DONE_BIT]) // [R11]
        else $error("done flag cleared by hardware");

    abort_fault_a: assert property (master_clear_reset_wdt_rst && st_ff.fsm != S_IDLE && !tbl_req.valid && !bus_wr |=>
                                    st_ff.fault && st_ff.fsm == S_IDLE && $stable(st_ff.addr_low)) // [R10]
        else $error("interrupted write not flagged or address lost");

    abort_hold_a: assert property (master_clear_reset_wdt_rst |=> !st_ff.go && !st_ff.permit && st_ff.fsm == S_IDLE) // [R10]
        else $error("reset event did not stop the write");

    commit_only_a: assert property (mem_we |-> st_ff.fsm == S_COMMIT && !master_clear_reset_wdt_rst) // [R19]
        else $error("array written outside commit");

    addr_capture_a: assert property (tbl_req.valid && tbl_req.write && tbl_in_ee |=>
                                     st_ff.addr_low == $past(tbl_req.addr[15:0])) // [R14]
        else $error("table write address not captured");

    tbl_answer_a: assert property (tbl_req.valid |=> tbl_rsp.valid && psv_suspend ##1 !$past(tbl_req.valid) ||
                                   tbl_rsp.valid) // [R5]
        else $error("table access not answered");

    block_len_a: assert property (st_ff.fsm == S_COMMIT && op_block && st_ff.cidx != 4'hf && !master_clear_reset_wdt_rst |=>
                                  st_ff.fsm == S_COMMIT) // [R2]
        else $error("block commit ended early");
endmodule : dewc_ctrl
`default_nettype wire

// ---- verilog/dewc_pkg.sv ----
// Constants, types and reset values of the data EEPROM write control block.
// Assumes one 200 MHz core clock and a core that issues table accesses as one-cycle requests.
// Function
// R1: EEPROM sits at 0x7FF000 to 0x7FFFFE.
// R2: Single-word or sixteen-word block operations.
// R3: Target address from upper and lower registers.
// R4: Write time about 2 ms, configurable.
// R5: Core keeps running during program or erase.
// R6: Software waits for completion before next operation.
// R7: Reads during programming may return anything.
// R8: Go bit set-only, cleared by hardware.
// R9: Write needs permit bit, clear after power-up.
// R10: Reset during write flags fault, keeps address.
// R11: Done flag set by hardware, software clears.
// R12: Unlock 0x55 then 0xAA before go.
// R13: Control value 0x400A selects block write.
// R14: Lower address captures each table write address; the code captures only table writes inside the EEPROM window.
// R15: Power-up timer blocks any write start.
// R16: Software erases locations before word writes.
// R17: Table read returns word at program address.
// R18: Visibility access suspended during table access.
// R19: Block words latched, committed after unlock and go.
package dewc_pkg;
    // Timing
    localparam int unsigned CLK_MHZ          = 200;
    localparam int unsigned WRITE_TIME_US    = 2000;
    localparam int unsigned WRITE_CYCLES_DEF = WRITE_TIME_US * CLK_MHZ;
    localparam int          CNT_W            = 20;
    localparam int          PROG_CNT_W       = 21;
    // EEPROM window in program space
    localparam logic [23:0] EE_BASE   = 24'h7ff000;
    localparam logic [23:0] EE_LAST   = 24'h7ffffe;
    localparam int          EE_IDX_W  = 11;
    localparam int          EE_WORDS  = 2048;
    localparam int          BLK_W     = 4;
    localparam int          BLK_WORDS = 16;
    localparam logic [15:0] ERASED_WORD = 16'hffff;
    // Register byte offsets
    localparam logic [4:0] OFS_CONTROL   = 5'h00;
    localparam logic [4:0] OFS_ADDR_LOW  = 5'h04;
    localparam logic [4:0] OFS_ADDR_UP   = 5'h08;
    localparam logic [4:0] OFS_UNLOCK    = 5'h0c;
    localparam logic [4:0] OFS_IRQ_FLAGS = 5'h10;
    localparam logic [4:0] OFS_IRQ_MASK  = 5'h14;
    // Control register fields
    localparam int CTL_GO_BIT     = 15;
    localparam int CTL_PERMIT_BIT = 14;
    localparam int CTL_FAULT_BIT  = 13;
    localparam int CTL_OP_LSB     = 0;
    localparam int CTL_OP_W       = 4;
    localparam logic [15:0] CTL_MULTI_PERMIT = 16'h400a;
    // Operation codes
    localparam logic [3:0] OP_WORD_WRITE  = 4'h4;
    localparam logic [3:0] OP_BLOCK_WRITE = 4'ha;
    localparam logic [3:0] OP_WORD_ERASE  = 4'h5;
    localparam logic [3:0] OP_BLOCK_ERASE = 4'h6;
    // Unlock keys
    localparam logic [7:0] KEY_FIRST  = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'haa;
    // Interrupt flag layout
    localparam int IRQ_W         = 2;
    localparam int IRQ_DONE_BIT  = 0;
    localparam int IRQ_FAULT_BIT = 1;

    typedef enum logic [1:0] {S_IDLE, S_PROGRAM, S_COMMIT} dewc_fsm_e;
    typedef enum logic [1:0] {KEY_NONE, KEY_HALF, KEY_ARMED} dewc_key_e;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic [23:0] addr;
        logic [15:0] wdata;
    } dewc_tbl_req_s;

    typedef struct packed {
        logic        valid;
        logic [15:0] rdata;
    } dewc_tbl_rsp_s;

    typedef struct packed {
        dewc_fsm_e        fsm;
        dewc_key_e        key;
        logic             go;
        logic             permit;
        logic             fault;
        logic [3:0]       op;
        logic [15:0]      addr_low;
        logic [7:0]       addr_up;
        logic [IRQ_W-1:0] flags;
        logic [IRQ_W-1:0] mask;
        logic [BLK_W-1:0] cidx;
        logic             wait_req;
        logic [31:0]      rdata;
        logic             rvalid;
        logic             psv_hold;
        logic             busy;
        logic             irq;
    } dewc_state_s;

    localparam dewc_state_s ST_RST = '{
        fsm: S_IDLE, key: KEY_NONE, go: 1'b0, permit: 1'b0, fault: 1'b0, op: 4'h0,
        addr_low: 16'h0000, addr_up: 8'h00, flags: 2'h0, mask: 2'h0, cidx: 4'h0,
        wait_req: 1'b1, rdata: 32'h0000_0000, rvalid: 1'b0, psv_hold: 1'b0, busy: 1'b0, irq: 1'b0};
endpackage : dewc_pkg

// ---- verilog/dewc_timer.sv ----
// Down counter that times one program or erase pass.
// Assumes load is at least one and start only comes while idle.
`timescale 1ns/1ps
`default_nettype none
module dewc_timer
    import dewc_pkg::*;
#(
    parameter int W = 20
) (
    // Clock and reset
    input  wire logic         mclk,
    input  wire logic         rst_n,
    // Control
    input  wire logic [W-1:0] load,
    input  wire logic         start,
    input  wire logic         abort,
    // Status
    output logic              running,
    output logic              expired
);
    typedef struct packed {
        logic [W-1:0] cnt;
        logic         run;
        logic         exp;
    } dewc_tmr_s;

    dewc_tmr_s tm_ff;
    dewc_tmr_s nxt_tm;

    always_comb begin
        nxt_tm = tm_ff;
        nxt_tm.exp = 1'b0;
        if (abort) begin
            nxt_tm.cnt = '0;
            nxt_tm.run = 1'b0;
        end else if (start) begin
            nxt_tm.cnt = load;
            nxt_tm.run = 1'b1;
        end else if (tm_ff.run) begin
            if (tm_ff.cnt == W'(1)) begin
                nxt_tm.run = 1'b0;
                nxt_tm.exp = 1'b1;
            end
            nxt_tm.cnt = tm_ff.cnt - W'(1);
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            tm_ff <= '0;
        end else begin
            tm_ff <= nxt_tm;
        end
    end

    assign running = tm_ff.run;
    assign expired = tm_ff.exp;
endmodule : dewc_timer
`default_nettype wire
